/* File: design/ccbu_defs.svh */
// Constants shared by the classify, compare and bit-clear datapath
`ifndef CCBU_DEFS_SVH
`define CCBU_DEFS_SVH

// ----------------------------------------------------------------
// Word and field layout
// ----------------------------------------------------------------
`define CCBU_WORD_W 32
`define CCBU_POS_W 5
`define CCBU_CONDITION_CODE_FIELD_LSB 0
`define CCBU_CONDITION_CODE_FIELD_MSB 2
`define CCBU_AC_STAT_LSB 3
`define CCBU_AC_STAT_MSB 6
`define CCBU_AC_CLASS_MSB 5
`define CCBU_AC_RESET 32'h0000_0000

// ----------------------------------------------------------------
// Condition codes
// ----------------------------------------------------------------
`define CCBU_CC_LT 3'h4
`define CCBU_CC_EQ 3'h2
`define CCBU_CC_GT 3'h1
`define CCBU_CC_NONE 3'h0

// ----------------------------------------------------------------
// Real number classes (low three status bits)
// ----------------------------------------------------------------
`define CCBU_CLS_ZERO 3'h0
`define CCBU_CLS_DENORM 3'h1
`define CCBU_CLS_NORMAL 3'h2
`define CCBU_CLS_INF 3'h3
`define CCBU_CLS_QUIET_NOT_A_NUMBER 3'h4
`define CCBU_CLS_SIGNALING_NOT_A_NUMBER 3'h5
`define CCBU_CLS_RSVD 3'h6

// ----------------------------------------------------------------
// Real formats
// ----------------------------------------------------------------
`define CCBU_SR_EXP_W 8
`define CCBU_SR_FRAC_W 23
`define CCBU_LR_EXP_W 11
`define CCBU_LR_FRAC_W 52

`endif

/* File: design/ccbu_pkg.sv */
// Types shared by the classify, compare and bit-clear datapath
package ccbu_pkg;

  // Operation selected by the decoder
  typedef enum logic [1:0] {
    CCBU_OP_CLASS = 2'h0,
    CCBU_OP_CLRBIT = 2'h1,
    CCBU_OP_CMP = 2'h2,
    CCBU_OP_CMPDEC = 2'h3
  } ccbu_op_e;

endpackage : ccbu_pkg

/* File: design/ccbu_classify.sv */
// Combinational classifier for one real number format
`timescale 1ns/1ps
`include "ccbu_defs.svh"

module ccbu_classify #(
  parameter int EXP_W = `CCBU_SR_EXP_W,
  parameter int FRAC_W = `CCBU_SR_FRAC_W
) (
  // Packed real: sign, exponent, fraction
  input wire logic [EXP_W+FRAC_W:0] value_i,
  // Classification result
  output logic sign_o,
  output logic [2:0] class_o
);

  // ----------------------------------------------------------------
  // Field split
  // ----------------------------------------------------------------
  logic [EXP_W-1:0] exp_w; // Biased exponent
  logic [FRAC_W-1:0] frac_w; // Fraction without hidden bit

  assign exp_w = value_i[EXP_W+FRAC_W-1:FRAC_W];
  assign frac_w = value_i[FRAC_W-1:0];
  assign sign_o = value_i[EXP_W+FRAC_W];

  // ----------------------------------------------------------------
  // Class decode
  // ----------------------------------------------------------------
  // Pure decode: there is no path by which a class raises an exception
  always_comb begin
    if (exp_w == '0) begin
      class_o = (frac_w == '0) ? `CCBU_CLS_ZERO : `CCBU_CLS_DENORM; // RQ1
    end else if (exp_w != '1) begin
      class_o = `CCBU_CLS_NORMAL; // RQ1
    end else if (frac_w == '0) begin
      class_o = `CCBU_CLS_INF; // RQ2
    end else if (frac_w[FRAC_W-1]) begin
      // Top fraction bit set marks the quiet kind
      class_o = `CCBU_CLS_QUIET_NOT_A_NUMBER; // RQ2
    end else begin
      class_o = `CCBU_CLS_SIGNALING_NOT_A_NUMBER; // RQ2
    end
  end

endmodule : ccbu_classify

/* File: design/ccbu_unit.sv */
// Classify, bit-clear, compare and compare-and-decrement datapath
`timescale 1ns/1ps
`include "ccbu_defs.svh"

// How it works
// RQ1 - Zero, denormal, normal: sign then 000/001/010
// RQ2 - Infinity, NaNs, reserved: sign then 011..110
// RQ3 - Classification never raises a floating exception
// RQ4 - Bit clear copies source, one bit zeroed
// RQ5 - Compare sets 100 less, 010 equal, 001
// RQ6 - Signed or unsigned compare follows variant
// RQ7 - Compare-decrement writes second operand minus one
// RQ8 - Signed decrement wraps without overflow fault
// RQ9 - Stored code drives later conditional branch
// RQ10 - Class fills status bits 3-6 only
// RQ11 - Long real source names even register pair
// RQ12 - Operands and results are 32-bit words
// RQ13 - Non-compare operations keep condition code

module ccbu_unit #(
  parameter int WORD_W = `CCBU_WORD_W,
  parameter int POS_W = `CCBU_POS_W,
  parameter int REG_IDX_W = 5
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // Operation request from the decoder
  input wire logic op_valid_i,
  input ccbu_pkg::ccbu_op_e op_i,
  input wire logic op_signed_i,
  input wire logic op_long_i,
  input wire logic [WORD_W-1:0] src1_i,
  input wire logic [WORD_W-1:0] src2_i,
  input wire logic [WORD_W-1:0] src2_hi_i,
  input wire logic [REG_IDX_W-1:0] dst_idx_i,
  // Direct load of the arithmetic controls
  input wire logic ac_load_i,
  input wire logic [WORD_W-1:0] ac_load_data_i,
  // Branch query on the stored condition code
  input wire logic [2:0] branch_mask_i,
  output logic branch_taken_o,
  // Register file write
  output logic rf_we_o,
  output logic [REG_IDX_W-1:0] rf_waddr_o,
  output logic [WORD_W-1:0] rf_wdata_o,
  // Arithmetic controls
  output logic [WORD_W-1:0] ac_o,
  output logic [2:0] condition_code_field_o
);

  import ccbu_pkg::*;

  // ----------------------------------------------------------------
  // Operation strobes
  // ----------------------------------------------------------------
  logic do_class_w; // Classification this cycle
  logic do_clr_w; // Bit clear this cycle
  logic do_cmp_w; // Either compare form this cycle
  logic do_dec_w; // Compare-and-decrement this cycle

  assign do_class_w = op_valid_i && (op_i == CCBU_OP_CLASS);
  assign do_clr_w = op_valid_i && (op_i == CCBU_OP_CLRBIT);
  assign do_dec_w = op_valid_i && (op_i == CCBU_OP_CMPDEC);
  assign do_cmp_w = (op_valid_i && (op_i == CCBU_OP_CMP)) || do_dec_w;

  // ----------------------------------------------------------------
  // Classification
  // ----------------------------------------------------------------
  logic sr_sign_w; // Single real sign
  logic [2:0] sr_class_w; // Single real class
  logic lr_sign_w; // Long real sign
  logic [2:0] lr_class_w; // Long real class
  logic cls_sign_w; // Selected sign
  logic [2:0] cls_code_w; // Selected class

  // Single real held in the one source word
  ccbu_classify #(
    .EXP_W(`CCBU_SR_EXP_W),
    .FRAC_W(`CCBU_SR_FRAC_W)
  ) u_class_single (
    .value_i(src2_i),
    .sign_o(sr_sign_w),
    .class_o(sr_class_w)
  );

  // Long real: the decoder hands the even register and its partner
  ccbu_classify #(
    .EXP_W(`CCBU_LR_EXP_W),
    .FRAC_W(`CCBU_LR_FRAC_W)
  ) u_class_long (
    .value_i({src2_hi_i, src2_i}), // RQ11
    .sign_o(lr_sign_w),
    .class_o(lr_class_w)
  );

  // Pick the format; these formats have no reserved encoding, so the
  // reserved class code is never produced here
  assign cls_sign_w = op_long_i ? lr_sign_w : sr_sign_w; // RQ1
  assign cls_code_w = op_long_i ? lr_class_w : sr_class_w; // RQ2

  // ----------------------------------------------------------------
  // Compare
  // ----------------------------------------------------------------
  logic lt_w; // First operand below second
  logic eq_w; // Operands equal
  logic [2:0] cmp_cc_w; // Code to store

  // One comparator, signedness chosen per variant
  always_comb begin
    if (op_signed_i) begin
      lt_w = $signed(src1_i) < $signed(src2_i); // RQ6
    end else begin
      lt_w = src1_i < src2_i; // RQ6
    end
  end

  assign eq_w = (src1_i == src2_i);

  // Less wins, then equal, everything else is greater
  always_comb begin
    if (lt_w) begin
      cmp_cc_w = `CCBU_CC_LT; // RQ5
    end else if (eq_w) begin
      cmp_cc_w = `CCBU_CC_EQ; // RQ5
    end else begin
      cmp_cc_w = `CCBU_CC_GT; // RQ5
    end
  end

  // ----------------------------------------------------------------
  // Word results
  // ----------------------------------------------------------------
  logic [WORD_W-1:0] clr_mask_w; // One zero at the chosen bit
  logic [WORD_W-1:0] clr_res_w; // Bit clear result
  logic [WORD_W-1:0] dec_res_w; // Decrement result

  // Only the low position bits are used, giving the modulo wrap
  assign clr_mask_w = ~({{(WORD_W-1){1'b0}}, 1'b1} << src1_i[POS_W-1:0]);
  assign clr_res_w = src2_i & clr_mask_w; // RQ4
  // Plain modular subtract: wrapping past the minimum is silent
  assign dec_res_w = src2_i - {{(WORD_W-1){1'b0}}, 1'b1}; // RQ7 RQ8

  // ----------------------------------------------------------------
  // Register file write port
  // ----------------------------------------------------------------
  // One cycle pulse after the request; classify and plain compare never write
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      rf_we_o <= 1'b0;
    end else begin
      rf_we_o <= do_clr_w || do_dec_w; // RQ12
    end
  end

  // Address and data only load on a write, keeping the bus quiet
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      rf_waddr_o <= '0;
      rf_wdata_o <= '0;
    end else if (do_clr_w) begin
      rf_waddr_o <= dst_idx_i;
      rf_wdata_o <= clr_res_w; // RQ4 RQ12
    end else if (do_dec_w) begin
      rf_waddr_o <= dst_idx_i;
      rf_wdata_o <= dec_res_w; // RQ7
    end
  end

  // ----------------------------------------------------------------
  // Arithmetic controls
  // ----------------------------------------------------------------
  logic [WORD_W-1:0] ac_d; // Next arithmetic controls
  logic [WORD_W-1:0] ac_q; // Arithmetic controls

  // A direct load lands first; an operation in the same cycle then
  // overrides just its own field, so the load keeps every other bit
  always_comb begin
    ac_d = ac_load_i ? ac_load_data_i : ac_q;
    if (do_class_w) begin
      ac_d[`CCBU_AC_STAT_MSB] = cls_sign_w; // RQ10
      ac_d[`CCBU_AC_CLASS_MSB:`CCBU_AC_STAT_LSB] = cls_code_w; // RQ10
    end else if (do_cmp_w) begin
      ac_d[`CCBU_CONDITION_CODE_FIELD_MSB:`CCBU_CONDITION_CODE_FIELD_LSB] = cmp_cc_w; // RQ5
    end
    // Bit clear falls through and leaves the code alone (RQ13)
  end

  // Controls register
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      ac_q <= `CCBU_AC_RESET;
    end else begin
      ac_q <= ac_d;
    end
  end

  assign ac_o = ac_q;
  assign condition_code_field_o = ac_q[`CCBU_CONDITION_CODE_FIELD_MSB:`CCBU_CONDITION_CODE_FIELD_LSB];

  // ----------------------------------------------------------------
  // Branch evaluation
  // ----------------------------------------------------------------
  // Mask zero asks for an unordered code, any other mask tests bits;
  // this equals what a fused compare-and-branch would decide
  always_comb begin
    if (branch_mask_i == `CCBU_CC_NONE) begin
      branch_taken_o = (condition_code_field_o == `CCBU_CC_NONE); // RQ9
    end else begin
      branch_taken_o = |(condition_code_field_o & branch_mask_i); // RQ9
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);

  // Helper: code a fused branch would derive from the operands
  logic [2:0] ref_cc_w;
  assign ref_cc_w = lt_w ? `CCBU_CC_LT : (eq_w ? `CCBU_CC_EQ : `CCBU_CC_GT);

  sequence s_cmp_signed_lt;
    do_cmp_w && op_signed_i && !ac_load_i &&
      ($signed(src1_i) < $signed(src2_i));
  endsequence

  sequence s_cmp_unsigned_gt;
    do_cmp_w && !op_signed_i && !ac_load_i && (src1_i > src2_i);
  endsequence

  sequence s_cmp_then_query;
    do_cmp_w && !ac_load_i ##1 (!do_cmp_w && !ac_load_i);
  endsequence

  AST_CLASS_SIGN: assert property ( // RQ1
    do_class_w |=> ac_o[`CCBU_AC_STAT_MSB] == $past(cls_sign_w))
    else $error("class sign bit wrong");

  AST_CLASS_CODE: assert property ( // RQ2
    do_class_w |=> ac_o[`CCBU_AC_CLASS_MSB:`CCBU_AC_STAT_LSB] ==
      $past(cls_code_w))
    else $error("class code wrong");

  AST_CLASS_KEEPS_REST: assert property ( // RQ10
    do_class_w && !ac_load_i |=>
      ac_o[`CCBU_CONDITION_CODE_FIELD_MSB:`CCBU_CONDITION_CODE_FIELD_LSB] ==
        $past(ac_o[`CCBU_CONDITION_CODE_FIELD_MSB:`CCBU_CONDITION_CODE_FIELD_LSB]) &&
      ac_o[WORD_W-1:`CCBU_AC_STAT_MSB+1] ==
        $past(ac_o[WORD_W-1:`CCBU_AC_STAT_MSB+1]))
    else $error("class touched other control bits");

  AST_CLASS_NO_WRITE: assert property ( // RQ3
    do_class_w |=> !rf_we_o)
    else $error("classification wrote a register");

  AST_CLRBIT: assert property ( // RQ4
    do_clr_w |=> rf_we_o && rf_waddr_o == $past(dst_idx_i) &&
      rf_wdata_o == ($past(src2_i) &
        ~({{(WORD_W-1){1'b0}}, 1'b1} << $past(src1_i[POS_W-1:0]))))
    else $error("bit clear result wrong");

  AST_CLRBIT_KEEPS_CC: assert property ( // RQ13
    do_clr_w && !ac_load_i |=> $stable(condition_code_field_o))
    else $error("bit clear changed condition code");

  AST_CMP_SIGNED_LT: assert property ( // RQ5 RQ6
    s_cmp_signed_lt |=> condition_code_field_o == `CCBU_CC_LT)
    else $error("signed less code wrong");

  AST_CMP_UNSIGNED_GT: assert property ( // RQ6
    s_cmp_unsigned_gt |=> condition_code_field_o == `CCBU_CC_GT)
    else $error("unsigned greater code wrong");

  AST_DEC_RESULT: assert property ( // RQ7
    do_dec_w |=> rf_we_o && rf_wdata_o == $past(src2_i) - 32'h1)
    else $error("decrement result wrong");

  AST_DEC_WRAP: assert property ( // RQ8
    do_dec_w && src2_i == 32'h8000_0000 |=>
      rf_wdata_o == 32'h7fff_ffff)
    else $error("decrement past minimum did not wrap");

  AST_BRANCH_MATCH: assert property ( // RQ9
    s_cmp_then_query |->
      branch_taken_o == ((branch_mask_i == `CCBU_CC_NONE) ? 1'b0 :
        |($past(ref_cc_w) & branch_mask_i)))
    else $error("branch disagrees with compare");

endmodule : ccbu_unit

/* File: bench/ccbu_rf_model.sv */
// Register file model on the far side of the datapath write port
`timescale 1ns/1ps

module ccbu_rf_model (
  // Clock
  input wire logic clk_i,
  // Write port from the datapath
  input wire logic we_i,
  input wire logic [4:0] waddr_i,
  input wire logic [31:0] wdata_i,
  // Read port for the decoder side
  input wire logic [4:0] raddr_i,
  output logic [31:0] rdata_o,
  output logic [31:0] rdata_hi_o
);
  logic [31:0] regs_q [32]; // General registers
  initial foreach (regs_q[i]) regs_q[i] = 32'h0;
  // Store each written word, one write per cycle at most
  always @(posedge clk_i) begin
    if (we_i) regs_q[waddr_i] <= wdata_i;
  end
  // Long operand: named even register plus the one above it
  assign rdata_o = regs_q[raddr_i];
  assign rdata_hi_o = regs_q[raddr_i | 5'h1];
endmodule : ccbu_rf_model

/* File: bench/classify_compare_bitclear_unit_test.sv */
// Self-checking bench for the classify, compare and bit-clear unit
`timescale 1ns/1ps

module classify_compare_bitclear_unit_test;
  import ccbu_pkg::*;
  typedef struct {
    logic [31:0] ac;
    logic we;
    logic [4:0] a;
    logic [31:0] d;
  } ccbu_note_s;
  logic clk, reset, op_valid, op_signed, op_long, ac_load, seen_q;
  ccbu_op_e op;
  logic [31:0] src1, src2, src2_hi, ac_load_data, ac_exp, lo, hi;
  logic [31:0] rf_wdata, ac, rdata, rdata_hi;
  logic [4:0] dst_idx, rf_waddr, raddr;
  logic [2:0] branch_mask, cc;
  logic branch_taken, rf_we, lg;
  ccbu_note_s notes[$]; // Expected results, oldest first
  ccbu_note_s n; // Note being built by the driver
  ccbu_note_s got; // Note taken off the queue by the watcher
  int err_count, tests_run;

  ccbu_unit DUT (.clk_i(clk), .reset_i(reset), .op_valid_i(op_valid),
    .op_i(op), .op_signed_i(op_signed), .op_long_i(op_long),
    .src1_i(src1), .src2_i(src2), .src2_hi_i(src2_hi),
    .dst_idx_i(dst_idx), .ac_load_i(ac_load),
    .ac_load_data_i(ac_load_data), .branch_mask_i(branch_mask),
    .branch_taken_o(branch_taken), .rf_we_o(rf_we),
    .rf_waddr_o(rf_waddr), .rf_wdata_o(rf_wdata), .ac_o(ac),
    .condition_code_field_o(cc));
  ccbu_rf_model RF (.clk_i(clk), .we_i(rf_we), .waddr_i(rf_waddr),
    .wdata_i(rf_wdata), .raddr_i(raddr), .rdata_o(rdata),
    .rdata_hi_o(rdata_hi));

  // ----------------------------------------
  // Compare helpers
  // ----------------------------------------
  task automatic chk_w(input logic [31:0] g, e, input string m);
    tests_run++;
    if (g !== e) begin
      err_count++;
      $display("ERROR %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask : chk_w
  task automatic chk_b(input logic g, e, input string m);
    tests_run++;
    if (g !== e) begin
      err_count++;
      $display("ERROR %0t %s got %b exp %b", $time, m, g, e);
    end
  endtask : chk_b
  task automatic close_out;
    $display("Comparisons %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : close_out

  // Class code from sign, exponent and fraction of the operand
  function automatic logic [3:0] cls_of(input logic l,
                                        input logic [31:0] h, w);
    logic e0, e1, fz, fm;
    e0 = l ? ~|h[30:20] : ~|w[30:23];
    e1 = l ? &h[30:20] : &w[30:23];
    fz = l ? ~|{h[19:0], w} : ~|w[22:0];
    fm = l ? h[19] : w[22];
    return {l ? h[31] : w[31], e0 ? (fz ? 3'h0 : 3'h1) : !e1 ? 3'h2 :
            fz ? 3'h3 : fm ? 3'h4 : 3'h5};
  endfunction : cls_of

  // One request cycle; the expected outcome is noted as it is sent
  task automatic step(input logic v, input ccbu_op_e o, input logic sg,
    input logic l, input logic [31:0] a, b, h, input logic [4:0] d,
    input logic ld, input logic [31:0] ldd);
    logic [2:0] c;
    @(posedge clk);
    op_valid <= v; op <= o; op_signed <= sg; op_long <= l;
    src1 <= a; src2 <= b; src2_hi <= h; dst_idx <= d;
    ac_load <= ld; ac_load_data <= ldd;
    branch_mask <= 3'($urandom_range(7));
    n.ac = ld ? ldd : ac_exp;
    n.we = 1'b0;
    n.a = d;
    c = (sg ? $signed(a) < $signed(b) : a < b) ? 3'h4 :
        (a == b) ? 3'h2 : 3'h1;
    if (v) begin
      case (o)
        CCBU_OP_CLASS: n.ac[6:3] = cls_of(l, h, b);
        CCBU_OP_CLRBIT: begin
          n.we = 1'b1;
          n.d = b & ~(32'h1 << a[4:0]);
        end
        CCBU_OP_CMP: n.ac[2:0] = c;
        default: begin
          n.ac[2:0] = c;
          n.we = 1'b1;
          n.d = b - 32'h1;
        end
      endcase
    end
    if (v || ld) begin
      notes.push_back(n);
      ac_exp = n.ac;
    end
  endtask : step
  task automatic idle;
    step(0, CCBU_OP_CLASS, 0, 0, 0, 0, 0, 0, 0, 0);
  endtask : idle

  // ----------------------------------------
  // Result watcher
  // ----------------------------------------
  always @(posedge clk) seen_q <= !reset && (op_valid || ac_load);
  always @(negedge clk) begin
    if (!reset && seen_q) begin
      got = notes.pop_front();
      chk_w(ac, got.ac, "ac");
      chk_w({29'h0, cc}, {29'h0, got.ac[2:0]}, "cc");
      chk_b(rf_we, got.we, "we");
      chk_b(branch_taken, branch_mask == 3'h0 ? got.ac[2:0] == 3'h0 :
            |(got.ac[2:0] & branch_mask), "branch");
      if (got.we) begin
        chk_w({27'h0, rf_waddr}, {27'h0, got.a}, "waddr");
        chk_w(rf_wdata, got.d, "wdata");
      end
    end else if (!reset) chk_b(rf_we, 1'b0, "idle we");
  end

  // Clock at 20 MHz
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // Watchdog well beyond the fewer than two hundred cycles of stimulus
  initial begin
    repeat (3000) @(posedge clk);
    err_count++;
    close_out();
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    void'($urandom(32'hd5ae));
    {reset, op_valid, op_signed, op_long, ac_load} = 5'h10;
    op = CCBU_OP_CLASS;
    {src1, src2, src2_hi, ac_load_data} = 128'h0;
    {dst_idx, branch_mask, raddr, ac_exp} = {5'h0, 3'h0, 5'h5, 32'h0};
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    @(negedge clk);
    chk_w(ac, 32'h0, "reset ac");
    chk_b(rf_we, 1'b0, "reset we");
    // Classes of both formats, some with a load in the same cycle
    for (int i = 0; i < 48; i++) begin
      lg = 1'($urandom_range(1));
      {lo, hi} = {$urandom, $urandom};
      case ($urandom_range(3))
        0: if (lg) hi[30:20] = '0; else lo[30:23] = '0;
        1: if (lg) hi[30:20] = '1; else lo[30:23] = '1;
        default: ;
      endcase
      if ($urandom_range(2) == 0) begin
        if (lg) {hi[19:0], lo} = 52'h0; else lo[22:0] = 23'h0;
      end
      step(1, CCBU_OP_CLASS, 1'($urandom_range(1)), lg, $urandom, lo,
           hi, 5'($urandom), 1'($urandom_range(1)), $urandom);
    end
    idle();
    $display("classify test done");
    // Every bit position, positions past 31 wrap
    for (int i = 0; i < 40; i++)
      step(1, CCBU_OP_CLRBIT, 0, 0, i, $urandom, 0, 5'(i), 0, 0);
    idle();
    $display("bit clear test done");
    // Boundary pairs in both variants, then random pairs
    for (int i = 0; i < 48; i++) begin
      case (i % 6)
        0: {lo, hi} = {32'hffffffff, 32'h1};
        1: {lo, hi} = {32'h80000000, 32'h7fffffff};
        2: {lo, hi} = {32'h7fffffff, 32'h80000000};
        3: {lo, hi} = {32'h5, 32'h5};
        default: {lo, hi} = {$urandom, $urandom};
      endcase
      step(1, ccbu_op_e'(2 + i % 2), 1'(i / 6 % 2), 0, lo, hi, 0,
           5'($urandom), 1'(i > 30), $urandom);
    end
    idle();
    $display("compare test done");
    // Count down through the minimum integer using the stored result
    step(1, CCBU_OP_CMPDEC, 1, 0, 32'h80000000, 32'h80000002, 0, 5, 0, 0);
    repeat (3) begin
      repeat (3) idle();
      step(1, CCBU_OP_CMPDEC, 1, 0, 32'h80000000, rdata, 0, 5, 0, 0);
    end
    // Long quiet NaN built in an even register pair
    step(1, CCBU_OP_CLRBIT, 0, 0, 1, 32'h3, 0, 6, 0, 0);
    step(1, CCBU_OP_CLRBIT, 0, 0, 31, 32'hfff80001, 0, 7, 0, 0);
    raddr <= 5'h6;
    repeat (3) idle();
    step(1, CCBU_OP_CLASS, 0, 1, 0, rdata, rdata_hi, 0, 0, 0);
    idle();
    $display("loop and pair test done");
    // Second reset in mid-run
    @(posedge clk);
    reset <= 1'b1;
    @(posedge clk);
    reset <= 1'b0;
    ac_exp = 32'h0;
    @(negedge clk);
    chk_w(ac, 32'h0, "second reset ac");
    chk_b(rf_we, 1'b0, "second reset we");
    chk_w(rf_wdata, 32'h0, "second reset wdata");
    // First request at the first edge after the release
    step(1, CCBU_OP_CMPDEC, 0, 0, 32'h2, 32'h1, 0, 3, 0, 0);
    idle();
    // Let the watcher take the last note before checking the queue
    @(posedge clk);
    chk_b(notes.size() == 0, 1'b1, "notes left over");
    $display("reset test done");
    close_out();
  end
endmodule : classify_compare_bitclear_unit_test
